// ==== dv/tweep_master.sv ====
// two-wire bus master model: drives the serial clock and pulls the data line
`default_nettype none

module tweep_master (
	// wire level with pull-up
	input  wire logic i_sda,
	// bus drives
	output var  logic o_scl,
	output var  logic o_sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// clock idles high and stands still between frames
	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic tick(input int n);
		#(n * 10);
	endtask

	// data moves only in the low phase, sampled mid-high
	task automatic put(input logic b, output logic r);
		tick(4);
		o_sda_oe = !b;
		tick(4);
		o_scl = 1'b1;
		tick(4);
		r = i_sda;
		tick(4);
		o_scl = 1'b0;
	endtask

	task automatic start();
		// frames begin on a fixed phase, clear of the system clock's rising edges
		#((18 - ($time % 10)) % 10);
		o_sda_oe = 1'b0;
		// a full low phase lets the slave drop its acknowledge before the clock rises
		tick(8);
		o_scl = 1'b1;
		tick(8);
		o_sda_oe = 1'b1;
		tick(8);
		o_scl = 1'b0;
	endtask

	task automatic stop();
		tick(4);
		o_sda_oe = 1'b1;
		tick(4);
		o_scl = 1'b1;
		tick(8);
		o_sda_oe = 1'b0;
		tick(8);
	endtask

	// eight bits then the ninth: master drives mack, reads back the wire
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic sack);
		for (int i = 7; i >= 0; i--) begin
			put(d[i], q[i]);
		end
		put(mack, sack);
	endtask
endmodule

`default_nettype wire

// ==== dv/tweep_top_sva.sv ====
// pin-level checks on the two-wire eeprom slave
`default_nettype none

module tweep_top_sva
	import tweep_pkg::*;
#(
	parameter int unsigned WC_CYCLES = TWEEP_WC_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	input wire logic i_write_protect,
	input wire logic o_busy
);
	logic [31:0] busy_cnt_q;

	always_ff @(posedge i_clock) begin
		if (i_rst || !o_busy) begin
			busy_cnt_q <= '0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 32'h1;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_open_drain_low: assert property (o_sda_oe |-> !o_sda_o)
		else $error("data pin driven high");
	a_oe_steady_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
		else $error("data out moved while clock high");
	a_oe_after_fall: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 3))
		else $error("data out changed too soon after clock fall");
	a_no_ack_busy: assert property (o_busy |-> !o_sda_oe)
		else $error("acknowledge during programming");
	a_busy_at_stop: assert property ($rose(o_busy) |-> i_scl && i_sda && !i_write_protect)
		else $error("programming started without stop or while protected");
	a_busy_held: assert property ($rose(o_busy) |-> o_busy [*8])
		else $error("programming interval cut short");
	a_busy_length: assert property ($fell(o_busy) |-> busy_cnt_q + 2 >= WC_CYCLES && busy_cnt_q <= WC_CYCLES + 2)
		else $error("programming interval length wrong");
	a_standby_reset: assert property ($fell(i_rst) |-> !o_busy && !o_sda_oe)
		else $error("not in standby after reset");
endmodule

bind tweep_top tweep_top_sva #(.WC_CYCLES(WC_CYCLES)) u_tweep_top_sva (
	.i_clock, .i_rst, .i_scl, .i_sda, .o_sda_o, .o_sda_oe, .i_write_protect, .o_busy);

`default_nettype wire

// ==== dv/tweep_top_tb_top.sv ====
// self-checking bench for the two-wire eeprom slave
`default_nettype none

module tweep_top_tb_top;
	import tweep_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int WC = 400;

	logic       i_clock;
	logic       i_rst;
	logic       cs;
	logic       wp;
	logic       m_scl;
	logic       m_oe;
	logic       d_o;
	logic       d_oe;
	logic       busy;
	wire logic  sda;
	logic [7:0] ref_mem [1024];
	logic [7:0] rnd;
	int         mismatches;
	int         compares;

	// pull-up: low when either party pulls
	assign sda = !(m_oe || d_oe);

	tweep_top #(.WC_CYCLES(WC)) u_tweep_top (.i_clock(i_clock), .i_rst(i_rst), .i_scl(m_scl), .i_sda(sda),
		.o_sda_o(d_o), .o_sda_oe(d_oe), .i_chip_select_pin(cs), .i_write_protect(wp), .o_busy(busy));
	tweep_master u_tweep_master (.i_sda(sda), .o_scl(m_scl), .o_sda_oe(m_oe));

	initial i_clock = 1'b0;
	always #5 i_clock = ~i_clock;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic complete_run();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic sendb(input logic [7:0] d, input logic exp_ack);
		logic [7:0] q;
		logic       a;
		u_tweep_master.xfer(d, 1'b1, q, a);
		chk({7'h00, a}, {7'h00, !exp_ack});
		chk({7'h00, d_o}, 8'h00);
	endtask

	task automatic dev(input logic [9:0] a, input logic rd, input logic exp_ack);
		u_tweep_master.start();
		sendb({TWEEP_DEV_CODE, cs, a[9:8], rd}, exp_ack);
	endtask

	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busy !== lvl && n < lim) begin
			@(posedge i_clock);
			n++;
		end
		if (busy !== lvl) begin
			mismatches++;
			$display("mismatch at %0t: busy wait ran out", $time);
			complete_run();
		end
	endtask

	task automatic wr(input logic [9:0] a, input int n, input logic prot);
		logic [9:0] p;
		p = a;
		@(posedge i_clock);
		wp <= prot;
		dev(a, 1'b0, 1'b1);
		sendb(a[7:0], 1'b1);
		repeat (n) begin
			rnd = lfsr(rnd);
			sendb(rnd, 1'b1);
			if (!prot) begin
				ref_mem[p] = rnd;
			end
			p = {p[9:4], p[3:0] + 4'h1};
		end
		u_tweep_master.stop();
		if (prot) begin
			repeat (40) @(posedge i_clock);
			chk({7'h00, busy}, 8'h00);
		end else begin
			wait_busy(1'b1, 20);
			dev(a, 1'b0, 1'b0);
			u_tweep_master.stop();
			wait_busy(1'b0, WC + 20);
			dev(a, 1'b0, 1'b1);
			u_tweep_master.stop();
		end
		@(posedge i_clock);
		wp <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input int n);
		logic [7:0] q;
		logic       s;
		logic [9:0] p;
		p = a;
		dev(a, 1'b0, 1'b1);
		sendb(a[7:0], 1'b1);
		dev(a, 1'b1, 1'b1);
		for (int i = 1; i <= n; i++) begin
			u_tweep_master.xfer(8'hFF, i == n, q, s);
			chk(q, ref_mem[p]);
			p = p + 10'h001;
		end
		u_tweep_master.stop();
	endtask

	initial begin
		logic [7:0] q;
		logic       s;
		i_rst      = 1'b1;
		wp         = 1'b0;
		rnd        = 8'h51;
		cs         = rnd[0];
		mismatches = 0;
		compares   = 0;
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (5) @(posedge i_clock);
		chk({6'h00, busy, d_oe}, 8'h00);
		u_tweep_master.start();
		sendb(8'h50, 1'b0);
		u_tweep_master.stop();
		u_tweep_master.start();
		sendb({TWEEP_DEV_CODE, !cs, 3'h0}, 1'b0);
		u_tweep_master.stop();
		wr(10'h3FE, 18, 1'b0);
		// current-address read: the counter sits on the column after the last loaded byte
		dev(10'h000, 1'b1, 1'b1);
		u_tweep_master.xfer(8'hFF, 1'b1, q, s);
		chk(q, ref_mem[10'h3F0]);
		u_tweep_master.stop();
		wr(10'h000, 2, 1'b0);
		wr(10'h000, 1, 1'b1);
		// bus recovery: start, eighteen released bits, then a fresh command
		u_tweep_master.start();
		u_tweep_master.xfer(8'hFF, 1'b1, q, s);
		u_tweep_master.xfer(8'hFF, 1'b1, q, s);
		rd(10'h3FC, 6);
		complete_run();
	end
endmodule

`default_nettype wire

// ==== verilog/tweep_link_if.sv ====
// carrier between the serial-clock sampler and the core
`default_nettype none

interface tweep_link_if;
	logic sda_pin;
	logic bit_tgl;
	logic bit_val;

	modport sampler (
		input  sda_pin,
		output bit_tgl,
		output bit_val
	);

	modport core (
		input  bit_tgl,
		input  bit_val
	);
endinterface

`default_nettype wire

// ==== verilog/tweep_link_sampler.sv ====
// serial-clock domain: captures each data bit on the clock's rising edge
`default_nettype none

module tweep_link_sampler
	import tweep_pkg::*;
(
	// link clock and reset
	input  wire logic      i_scl,
	input  wire logic      i_rst,
	// carrier to the core
	tweep_link_if.sampler  lnk
);

	logic tgl_q;
	logic val_q;

	// each rising edge stores the bit and flips the toggle; the value stays stable
	// for a whole serial period, far longer than the core's toggle synchroniser
	always_ff @(posedge i_scl or posedge i_rst) begin
		if (i_rst) begin
			tgl_q <= 1'b0;
			val_q <= 1'b0;
		end else begin
			tgl_q <= ~tgl_q;
			val_q <= lnk.sda_pin;
		end
	end

	assign lnk.bit_tgl = tgl_q;
	assign lnk.bit_val = val_q;

endmodule

`default_nettype wire

// ==== verilog/tweep_pkg.sv ====
// constants shared by the two-wire eeprom slave
`default_nettype none

package tweep_pkg;

	// ****************************************
	// array organisation
	// ****************************************
	localparam int unsigned TWEEP_ADDR_W     = 10;
	localparam int unsigned TWEEP_COL_W      = 4;
	localparam int unsigned TWEEP_ROW_W      = 6;
	localparam int unsigned TWEEP_BLK_W      = 2;
	localparam int unsigned TWEEP_PAGE_BYTES = 16;
	localparam int unsigned TWEEP_PAGES      = 64;
	localparam int unsigned TWEEP_MEM_BYTES  = TWEEP_PAGE_BYTES * TWEEP_PAGES;

	// ****************************************
	// device address byte layout
	// ****************************************
	localparam logic [3:0]  TWEEP_DEV_CODE     = 4'hA;
	localparam int unsigned TWEEP_DEV_CODE_MSB = 7;
	localparam int unsigned TWEEP_DEV_CODE_LSB = 4;
	localparam int unsigned TWEEP_DEV_CS_BIT   = 3;
	localparam int unsigned TWEEP_DEV_BLK_MSB  = 2;
	localparam int unsigned TWEEP_DEV_BLK_LSB  = 1;
	localparam int unsigned TWEEP_DEV_RW_BIT   = 0;

	// ****************************************
	// framing
	// ****************************************
	localparam logic [3:0]  TWEEP_BITS_PER_WORD = 4'h8;
	localparam logic [3:0]  TWEEP_LAST_DATA_BIT = 4'h7;
	localparam logic [3:0]  TWEEP_CNT_ZERO      = 4'h0;
	localparam logic [3:0]  TWEEP_CNT_ONE       = 4'h1;

	// ****************************************
	// pin synchroniser slots and their reset levels
	// ****************************************
	localparam int unsigned TWEEP_PINS    = 4;
	localparam int unsigned TWEEP_PIN_SCL = 0;
	localparam int unsigned TWEEP_PIN_SDA = 1;
	localparam int unsigned TWEEP_PIN_CS  = 2;
	localparam int unsigned TWEEP_PIN_WP  = 3;
	localparam logic [3:0]  TWEEP_PIN_RST = 4'h3;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned TWEEP_CLK_MHZ           = 100;
	localparam int unsigned TWEEP_WRITE_CYCLE_TIME_US = 5000;
	localparam int unsigned TWEEP_WC_CYCLES         = TWEEP_WRITE_CYCLE_TIME_US * TWEEP_CLK_MHZ;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WADDR,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT,
		ST_PROG
	} tweep_state_type;

endpackage

`default_nettype wire

// ==== verilog/tweep_top.sv ====
// two-wire eeprom slave: framing, addressing, byte/page write and reads
`default_nettype none

module tweep_top
	import tweep_pkg::*;
#(
	parameter int unsigned WC_CYCLES = TWEEP_WC_CYCLES
) (
	// system clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	// serial link
	input  wire logic i_scl,
	input  wire logic i_sda,
	output var  logic o_sda_o,
	output var  logic o_sda_oe,
	// straps
	input  wire logic i_chip_select_pin,
	input  wire logic i_write_protect,
	// status
	output var  logic o_busy
);

	localparam int unsigned TMR_W = $clog2(WC_CYCLES + 1);
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WC_CYCLES - 1);
	localparam logic [TMR_W-1:0] TMR_PAGE = TMR_W'(TWEEP_PAGE_BYTES);

	// ****************************************
	// decoding helpers
	// ****************************************
	// the ninth slot of every word carries an acknowledge from one side or the other
	function automatic logic ack_slot(input logic [3:0] cnt);
		return (cnt == TWEEP_BITS_PER_WORD);
	endfunction

	// ****************************************
	// link sampler in the serial clock domain
	// ****************************************
	tweep_link_if lnk ();

	assign lnk.sda_pin = i_sda;

	tweep_link_sampler u_sampler (
		.i_scl (i_scl),
		.i_rst (i_rst),
		.lnk   (lnk)
	);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [TWEEP_PINS-1:0] pin_raw;
	logic [TWEEP_PINS-1:0] pin_s1_q;
	logic [TWEEP_PINS-1:0] pin_s2_q;
	logic [TWEEP_PINS-1:0] pin_s3_q;
	logic [TWEEP_PINS-1:0] lvl_q;
	logic [TWEEP_PINS-1:0] lvl_d;

	// an open chip-select or write-protect pin is resolved low at the pad
	assign pin_raw = {i_write_protect, i_chip_select_pin, i_sda, i_scl};

	always_ff @(posedge i_clock) begin
		pin_s1_q <= pin_raw;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end

	// a level counts only once the second and third stages agree
	generate
		for (genvar g = 0; g < TWEEP_PINS; g++) begin : g_lvl
			always_comb begin
				lvl_d[g] = (pin_s2_q[g] == pin_s3_q[g]) ? pin_s3_q[g] : lvl_q[g];
			end
		end
	endgenerate

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			lvl_q <= TWEEP_PIN_RST;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic cs_lvl;
	logic wp_lvl;

	assign scl_fall = lvl_q[TWEEP_PIN_SCL] & ~lvl_d[TWEEP_PIN_SCL];
	assign start_ev = lvl_q[TWEEP_PIN_SCL] & lvl_d[TWEEP_PIN_SCL]
	                & lvl_q[TWEEP_PIN_SDA] & ~lvl_d[TWEEP_PIN_SDA];
	assign stop_ev  = lvl_q[TWEEP_PIN_SCL] & lvl_d[TWEEP_PIN_SCL]
	                & ~lvl_q[TWEEP_PIN_SDA] & lvl_d[TWEEP_PIN_SDA];
	assign cs_lvl   = lvl_q[TWEEP_PIN_CS];
	assign wp_lvl   = lvl_q[TWEEP_PIN_WP];

	// ****************************************
	// bit events from the serial clock domain
	// ****************************************
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic bit_ev;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= lnk.bit_tgl;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign bit_ev = tgl_s2_q ^ tgl_s3_q;

	// ****************************************
	// protocol state
	// ****************************************
	tweep_state_type          state_q;
	logic [3:0]               cnt_q;
	logic [7:0]               sr_q;
	logic [7:0]               byte_in;
	logic                     ack_q;
	logic                     oe_q;
	logic [7:0]               tx_q;
	logic [TWEEP_ADDR_W-1:0]  ctr_q;
	logic [TWEEP_BLK_W-1:0]   blk_q;
	logic [TWEEP_ROW_W-1:0]   row_q;
	logic [TWEEP_COL_W-1:0]   col_q;
	logic [TWEEP_PAGE_BYTES-1:0] mask_q;
	logic [TMR_W-1:0]         prog_cnt_q;
	logic                     prog_done;
	logic                     byte_end;
	logic                     dev_match;

	logic [7:0] mem_q [TWEEP_MEM_BYTES];
	logic [7:0] page_q [TWEEP_PAGE_BYTES];

	assign byte_in   = {sr_q[6:0], lnk.bit_val};
	assign byte_end  = bit_ev && (cnt_q == TWEEP_LAST_DATA_BIT);
	assign prog_done = (prog_cnt_q == TMR_LAST);
	assign dev_match = (byte_in[TWEEP_DEV_CODE_MSB:TWEEP_DEV_CODE_LSB] == TWEEP_DEV_CODE)
	                 && (byte_in[TWEEP_DEV_CS_BIT] == cs_lvl);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			cnt_q   <= TWEEP_CNT_ZERO;
			sr_q    <= 8'h00;
			ack_q   <= 1'b0;
			oe_q    <= 1'b0;
			tx_q    <= 8'h00;
			ctr_q   <= '0;
			blk_q   <= '0;
			row_q   <= '0;
			col_q   <= '0;
			mask_q  <= '0;
		end else if (state_q == ST_PROG) begin
			// inputs ignored and the data line left alone until the timer ends
			oe_q <= 1'b0;
			if (prog_done) begin
				state_q <= ST_IDLE;
			end
		end else if (start_ev) begin
			// a start aborts whatever was going on outside programming, including a bus recovery sequence
			state_q <= ST_DEV;
			cnt_q   <= TWEEP_CNT_ZERO;
			oe_q    <= 1'b0;
			ack_q   <= 1'b0;
		end else if (stop_ev) begin
			cnt_q <= TWEEP_CNT_ZERO;
			oe_q  <= 1'b0;
			ack_q <= 1'b0;
			if (state_q == ST_WDATA && mask_q != '0 && !wp_lvl) begin
				state_q <= ST_PROG;
				ctr_q   <= {row_q, col_q};
			end else begin
				state_q <= ST_IDLE;
			end
		end else begin
			if (bit_ev) begin
				if (!ack_slot(cnt_q)) begin
					sr_q  <= byte_in;
					cnt_q <= cnt_q + TWEEP_CNT_ONE;
				end else begin
					// ninth clock: in a read this is the master's acknowledge, except
					// right after the address byte, where the slot held our own
					// acknowledge (ack_q still high) and the first byte is already loaded
					cnt_q <= TWEEP_CNT_ZERO;
					if (state_q == ST_RDATA && !ack_q) begin
						if (!lnk.bit_val) begin
							tx_q  <= mem_q[ctr_q];
							ctr_q <= ctr_q + 1'b1;
						end else begin
							state_q <= ST_WAIT;
						end
					end
				end
			end
			if (byte_end) begin
				unique case (state_q)
					ST_DEV: begin
						if (dev_match) begin
							ack_q <= 1'b1;
							blk_q <= byte_in[TWEEP_DEV_BLK_MSB:TWEEP_DEV_BLK_LSB];
							if (byte_in[TWEEP_DEV_RW_BIT]) begin
								state_q <= ST_RDATA;
								tx_q    <= mem_q[ctr_q];
								ctr_q   <= ctr_q + 1'b1;
							end else begin
								state_q <= ST_WADDR;
							end
						end else begin
							ack_q   <= 1'b0;
							state_q <= ST_WAIT;
						end
					end
					ST_WADDR: begin
						ack_q   <= 1'b1;
						row_q   <= {blk_q, byte_in[7:TWEEP_COL_W]};
						col_q   <= byte_in[TWEEP_COL_W-1:0];
						ctr_q   <= {blk_q, byte_in};
						mask_q  <= '0;
						state_q <= ST_WDATA;
					end
					ST_WDATA: begin
						ack_q         <= 1'b1;
						mask_q[col_q] <= 1'b1;
						col_q         <= col_q + 1'b1;
					end
					ST_IDLE, ST_RDATA, ST_WAIT, ST_PROG: begin
						ack_q <= 1'b0;
					end
				endcase
			end
			// outgoing data only ever changes just after a falling edge
			if (scl_fall) begin
				if (ack_slot(cnt_q)) begin
					oe_q <= ack_q;
				end else if (state_q == ST_RDATA) begin
					oe_q <= ~tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end else begin
					oe_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// page buffer and programming
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (byte_end && state_q == ST_WDATA && !start_ev && !stop_ev) begin
			page_q[col_q] <= byte_in;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst || state_q != ST_PROG) begin
			prog_cnt_q <= '0;
		end else begin
			prog_cnt_q <= prog_cnt_q + 1'b1;
		end
	end

	// column being committed in this cycle of the interval
	logic [TWEEP_COL_W-1:0] prog_col;

	assign prog_col = prog_cnt_q[TWEEP_COL_W-1:0];

	// loaded columns are committed one per cycle at the start of the interval
	always_ff @(posedge i_clock) begin
		if (state_q == ST_PROG && prog_cnt_q < TMR_PAGE && mask_q[prog_col]) begin
			mem_q[{row_q, prog_col}] <= page_q[prog_col];
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// the pad only ever pulls low, so the data value stays low
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_sda_o <= 1'b0;
		end else begin
			o_sda_o <= 1'b0;
		end
	end

	// pull enable follows the protocol state one cycle later
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_sda_oe <= 1'b0;
		end else begin
			o_sda_oe <= oe_q;
		end
	end

	// busy marks the self-timed interval
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= (state_q == ST_PROG);
		end
	end

endmodule

`default_nettype wire

// ==== verilog/tweep_unused_placeholder_never.sv ====
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire
